// [rtl/cfg_word_reg.sv]
// one 16-bit configuration word at a fixed address
// assumes writes arrive only as completed commands on the carrier
`timescale 1ns/10ps
`default_nettype none
module cfg_word_reg
  import conv_cfg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] REG_ADDR = 8'h00,
  parameter logic [DATA_W-1:0] RESET_WORD = 16'h0000
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  cfg_wr_if.sink bus,
  output logic [DATA_W-1:0] o_word
);
  logic [DATA_W-1:0] word_r;
  logic [DATA_W-1:0] word_nxt;

  always_comb begin
    word_nxt = word_r;
    if (bus.clear) begin
      word_nxt = RESET_WORD;
    end else if (bus.wr_valid && (bus.addr == REG_ADDR)) begin
      word_nxt = bus.data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      word_r <= RESET_WORD;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign o_word = word_r;
endmodule // cfg_word_reg
`default_nettype wire

// [rtl/cfg_wr_if.sv]
// completed-write carrier between the bank and its word registers
// assumes one driver (the bank) and any number of word registers
`timescale 1ns/10ps
`default_nettype none
interface cfg_wr_if;
  import conv_cfg_pkg::*;
  logic wr_valid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic clear;
  modport src (output wr_valid, output addr, output data, output clear);
  modport sink (input wr_valid, input addr, input data, input clear);
endinterface
`default_nettype wire

// [rtl/conv_cfg_pkg.sv]
// constants, field layouts and reset words of the converter configuration bank
// assumes 16-bit register words reached by completed serial write commands
package conv_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CORES = 4;
  localparam int SRC_W = 5;
  localparam int SEL_W = 2;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE_DIV = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_SRC_12 = 8'h3A;
  localparam logic [ADDR_W-1:0] ADDR_SRC_34 = 8'h3B;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_FS_TRIM = 8'h55;

  // reset words
  localparam logic [DATA_W-1:0] RST_MODE_DIV = 16'h0004;
  localparam logic [DATA_W-1:0] RST_SRC_12 = 16'h0402;
  localparam logic [DATA_W-1:0] RST_SRC_34 = 16'h1008;
  localparam logic [DATA_W-1:0] RST_CURRENT = 16'h0010;
  localparam logic [DATA_W-1:0] RST_FS_TRIM = 16'h0020;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int CH_LSB = 0;
  localparam int CH_W = 3;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 2;
  localparam int SRC_LO_LSB = 0;
  localparam int SRC_HI_LSB = 8;
  localparam int CUR_LSB = 0;
  localparam int CUR_W = 3;
  localparam int CMB_LSB = 4;
  localparam int CMB_W = 2;
  localparam int TRIM_LSB = 0;
  localparam int TRIM_W = 6;

  // channel count codes, one-hot
  typedef enum logic [CH_W-1:0] {
    MODE_SINGLE = 3'h1,
    MODE_DUAL = 3'h2,
    MODE_QUAD = 3'h4
  } chan_mode_t;

  // branches interleaved per channel
  localparam logic [3:0] BR_SINGLE = 4'h8;
  localparam logic [3:0] BR_DUAL = 4'h4;
  localparam logic [3:0] BR_QUAD = 4'h2;
  localparam logic [3:0] BR_NONE = 4'h0;

  // clock divider codes
  localparam logic [DIV_W-1:0] DIV_CODE_1 = 2'h0;
  localparam logic [DIV_W-1:0] DIV_CODE_2 = 2'h1;
  localparam logic [DIV_W-1:0] DIV_CODE_4 = 2'h2;
  localparam logic [DIV_W-1:0] DIV_CODE_8 = 2'h3;
  localparam logic [3:0] DIV_FACTOR_1 = 4'h1;
  localparam logic [3:0] DIV_FACTOR_2 = 4'h2;
  localparam logic [3:0] DIV_FACTOR_4 = 4'h4;
  localparam logic [3:0] DIV_FACTOR_8 = 4'h8;
  localparam logic [2:0] DIV_LAST_1 = 3'h0;
  localparam logic [2:0] DIV_LAST_2 = 3'h1;
  localparam logic [2:0] DIV_LAST_4 = 3'h3;
  localparam logic [2:0] DIV_LAST_8 = 3'h7;

  // crosspoint source codes
  localparam logic [SRC_W-1:0] SRC_PAIR_1 = 5'h02;
  localparam logic [SRC_W-1:0] SRC_PAIR_2 = 5'h04;
  localparam logic [SRC_W-1:0] SRC_PAIR_3 = 5'h08;
  localparam logic [SRC_W-1:0] SRC_PAIR_4 = 5'h10;

  // trim, current and buffer codes
  localparam logic [TRIM_W-1:0] TRIM_NEUTRAL = 6'h20;
  localparam logic [CUR_W-1:0] CUR_NOMINAL = 3'h0;
  localparam logic [CUR_W-1:0] CUR_CUT_40 = 3'h4;
  localparam logic [CUR_W-1:0] CUR_STEP_MAX = 3'h4;
  localparam logic [CMB_W-1:0] CMB_OFF = 2'h0;
  localparam logic [CMB_W-1:0] CMB_LOW = 2'h1;
endpackage

// [rtl/converter_config_register_bank.sv]
// configuration register bank of a four-core interleaved converter
// assumes the serial control logic presents each finished write as a
// one-cycle strobe with address and word, on i_sys_clk
// Summary of operation
// - a one in the soft reset bit restores every register and clears itself
// - channel count decodes one-hot: single, dual, quad; quad by default
// - quad interleaves two branches, dual four, single all eight
// - dual pairs cores 1-2 and 3-4; quad maps core n to channel n
// - divider codes 00..11 give factors 1, 2, 4, 8; 00 by default
// - sampling rate is the input clock divided by the chosen factor
// - each core source field is five bits, zero lsb, two per word
// - source codes one-hot above bit zero select pairs one to four
// - any input pair may feed any core in every mode
// - source changes apply as soon as the carrying write completes
// - six-bit trim drives trim converter; 100000 neutral default
// - core current 000 nominal, 100..111 cut 40..10 percent, 001..011 banned
// - two-bit buffer strength in bits five and four, can switch off
// - buffer codes: 00 off, 01 low default, 10 medium, 11 high
`timescale 1ns/10ps
`default_nettype none
module converter_config_register_bank
  import conv_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr_valid,
  input wire logic [ADDR_W-1:0] i_cfg_wr_addr,
  input wire logic [DATA_W-1:0] i_cfg_wr_data,
  input wire logic [ADDR_W-1:0] i_cfg_rd_addr,
  output logic [DATA_W-1:0] o_cfg_rd_data,
  output logic o_mode_single,
  output logic o_mode_dual,
  output logic o_mode_quad,
  output logic o_mode_invalid,
  output logic [3:0] o_branches_per_channel,
  output logic [NUM_CORES*SEL_W-1:0] o_core_channel,
  output logic [3:0] o_clk_div_factor,
  output logic o_sample_tick,
  output logic [NUM_CORES*SEL_W-1:0] o_core_source_sel,
  output logic [NUM_CORES-1:0] o_core_source_valid,
  output logic [TRIM_W-1:0] o_full_scale_trim_code,
  output logic [CUR_W-1:0] o_core_current_code,
  output logic [CUR_W-1:0] o_core_current_cut_steps,
  output logic o_core_current_invalid,
  output logic [CMB_W-1:0] o_common_mode_buffer_strength,
  output logic o_cm_buffer_enable
);
  cfg_wr_if wr_bus ();

  logic soft_clear;
  logic [DATA_W-1:0] mode_word;
  logic [DATA_W-1:0] src12_word;
  logic [DATA_W-1:0] src34_word;
  logic [DATA_W-1:0] cur_word;
  logic [DATA_W-1:0] trim_word;
  logic [SRC_W-1:0] src_code [NUM_CORES];
  logic [DIV_W-1:0] div_code;
  logic [2:0] div_last;
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic div_touch;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [CUR_W-1:0] cur_code;

  // completed write, soft reset derived from it
  assign soft_clear = i_cfg_wr_valid && (i_cfg_wr_addr == ADDR_SOFT_RESET)
                      && i_cfg_wr_data[SOFT_RESET_BIT];
  assign wr_bus.wr_valid = i_cfg_wr_valid;
  assign wr_bus.addr = i_cfg_wr_addr;
  assign wr_bus.data = i_cfg_wr_data;
  assign wr_bus.clear = soft_clear;

  cfg_word_reg #(.REG_ADDR(ADDR_MODE_DIV), .RESET_WORD(RST_MODE_DIV)) u_mode_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(wr_bus.sink),
    .o_word(mode_word)
  );
  cfg_word_reg #(.REG_ADDR(ADDR_SRC_12), .RESET_WORD(RST_SRC_12)) u_src_12 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(wr_bus.sink),
    .o_word(src12_word)
  );
  cfg_word_reg #(.REG_ADDR(ADDR_SRC_34), .RESET_WORD(RST_SRC_34)) u_src_34 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(wr_bus.sink),
    .o_word(src34_word)
  );
  cfg_word_reg #(.REG_ADDR(ADDR_CURRENT), .RESET_WORD(RST_CURRENT)) u_current (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(wr_bus.sink),
    .o_word(cur_word)
  );
  cfg_word_reg #(.REG_ADDR(ADDR_FS_TRIM), .RESET_WORD(RST_FS_TRIM)) u_fs_trim (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(wr_bus.sink),
    .o_word(trim_word)
  );

  // operating mode and channel map
  always_comb begin
    o_mode_single = 1'b0;
    o_mode_dual = 1'b0;
    o_mode_quad = 1'b0;
    o_mode_invalid = 1'b0;
    o_branches_per_channel = BR_NONE;
    o_core_channel = '0;
    unique case (mode_word[CH_LSB +: CH_W])
      MODE_SINGLE: begin
        o_mode_single = 1'b1;
        o_branches_per_channel = BR_SINGLE;
      end
      MODE_DUAL: begin
        o_mode_dual = 1'b1;
        o_branches_per_channel = BR_DUAL;
        for (int c = 0; c < NUM_CORES; c++) begin
          o_core_channel[c*SEL_W +: SEL_W] = SEL_W'(c >> 1);
        end
      end
      MODE_QUAD: begin
        o_mode_quad = 1'b1;
        o_branches_per_channel = BR_QUAD;
        for (int c = 0; c < NUM_CORES; c++) begin
          o_core_channel[c*SEL_W +: SEL_W] = SEL_W'(c);
        end
      end
      // more or fewer than one bit set by the host
      default: o_mode_invalid = 1'b1;
    endcase
  end

  // clock divider
  assign div_code = mode_word[DIV_LSB +: DIV_W];
  always_comb begin
    o_clk_div_factor = DIV_FACTOR_1;
    div_last = DIV_LAST_1;
    unique case (div_code)
      DIV_CODE_1: begin
        o_clk_div_factor = DIV_FACTOR_1;
        div_last = DIV_LAST_1;
      end
      DIV_CODE_2: begin
        o_clk_div_factor = DIV_FACTOR_2;
        div_last = DIV_LAST_2;
      end
      DIV_CODE_4: begin
        o_clk_div_factor = DIV_FACTOR_4;
        div_last = DIV_LAST_4;
      end
      DIV_CODE_8: begin
        o_clk_div_factor = DIV_FACTOR_8;
        div_last = DIV_LAST_8;
      end
    endcase
  end

  // restart the count on any write that may change the factor
  assign div_touch = soft_clear || (i_cfg_wr_valid && (i_cfg_wr_addr == ADDR_MODE_DIV));
  always_comb begin
    div_cnt_nxt = div_cnt_r + 3'h1;
    if (div_touch || (div_cnt_r >= div_last)) begin
      div_cnt_nxt = '0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end
  assign o_sample_tick = (div_cnt_r == div_last);

  // crosspoint: any pair to any core
  always_comb begin
    src_code[0] = src12_word[SRC_LO_LSB +: SRC_W];
    src_code[1] = src12_word[SRC_HI_LSB +: SRC_W];
    src_code[2] = src34_word[SRC_LO_LSB +: SRC_W];
    src_code[3] = src34_word[SRC_HI_LSB +: SRC_W];
  end
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_xp
    crosspoint_decode u_xp (
      .i_code(src_code[c]),
      .o_sel(o_core_source_sel[c*SEL_W +: SEL_W]),
      .o_valid(o_core_source_valid[c])
    );
  end

  // trim, core current and buffer strength
  assign o_full_scale_trim_code = trim_word[TRIM_LSB +: TRIM_W];
  assign cur_code = cur_word[CUR_LSB +: CUR_W];
  assign o_core_current_code = cur_code;
  always_comb begin
    o_core_current_cut_steps = '0;
    o_core_current_invalid = 1'b0;
    if (cur_code[CUR_W-1]) begin
      o_core_current_cut_steps = CUR_STEP_MAX - {1'b0, cur_code[1:0]};
    end else if (cur_code != CUR_NOMINAL) begin
      o_core_current_invalid = 1'b1;
    end
  end
  assign o_common_mode_buffer_strength = cur_word[CMB_LSB +: CMB_W];
  assign o_cm_buffer_enable = (cur_word[CMB_LSB +: CMB_W] != CMB_OFF);

  // readback; soft reset word always reads zero
  always_comb begin
    unique case (i_cfg_rd_addr)
      ADDR_MODE_DIV: rd_data_nxt = mode_word;
      ADDR_SRC_12: rd_data_nxt = src12_word;
      ADDR_SRC_34: rd_data_nxt = src34_word;
      ADDR_CURRENT: rd_data_nxt = cur_word;
      ADDR_FS_TRIM: rd_data_nxt = trim_word;
      default: rd_data_nxt = RD_ZERO;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_data_r <= RD_ZERO;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end
  assign o_cfg_rd_data = rd_data_r;

  soft_reset_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    soft_clear |=> (mode_word == RST_MODE_DIV) && (src12_word == RST_SRC_12)
      && (src34_word == RST_SRC_34) && (cur_word == RST_CURRENT)
      && (trim_word == RST_FS_TRIM))
    else $error("soft reset did not restore defaults");

  mode_decode_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_wr_valid && !soft_clear && (i_cfg_wr_addr == ADDR_MODE_DIV)
      && (i_cfg_wr_data[CH_LSB +: CH_W] == MODE_SINGLE))
    |=> o_mode_single && !o_mode_dual && !o_mode_quad && !o_mode_invalid)
    else $error("single mode not decoded");

  branch_count_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_mode_dual |-> o_branches_per_channel == BR_DUAL)
    and (o_mode_quad |-> o_branches_per_channel == BR_QUAD))
    else $error("wrong branch count for mode");

  core_map_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_mode_dual |-> (o_core_channel[SEL_W +: SEL_W] == 2'h0)
      && (o_core_channel[2*SEL_W +: SEL_W] == 2'h1))
    else $error("dual mode core pairing wrong");

  divide_eight_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_sample_tick && (o_clk_div_factor == DIV_FACTOR_8) && !div_touch)
      ##1 (!div_touch)[*7]
    |=> o_sample_tick && !$past(o_sample_tick, 4))
    else $error("divide by eight tick spacing wrong");

  source_apply_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_wr_valid && !soft_clear && (i_cfg_wr_addr == ADDR_SRC_12)
      && (i_cfg_wr_data[SRC_LO_LSB +: SRC_W] == SRC_PAIR_3))
    |=> (o_core_source_sel[SEL_W-1:0] == 2'h2) && o_core_source_valid[0])
    else $error("source select not applied after write");

  hold_idle_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_cfg_wr_valid |=> $stable(mode_word) && $stable(src12_word)
      && $stable(src34_word) && $stable(cur_word) && $stable(trim_word))
    else $error("register changed without a write");

  current_cut_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_wr_valid && !soft_clear && (i_cfg_wr_addr == ADDR_CURRENT)
      && (i_cfg_wr_data[CUR_LSB +: CUR_W] == CUR_CUT_40))
    |=> (o_core_current_cut_steps == CUR_STEP_MAX) && !o_core_current_invalid)
    else $error("current cut not decoded");

  buffer_off_a:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cfg_wr_valid && !soft_clear && (i_cfg_wr_addr == ADDR_CURRENT)
      && (i_cfg_wr_data[CMB_LSB +: CMB_W] == CMB_OFF))
    |=> !o_cm_buffer_enable && (o_common_mode_buffer_strength == CMB_OFF))
    else $error("buffer not switched off after write");

  trim_default_a:
  assert property (@(posedge i_sys_clk)
    $fell(i_rst) |-> (o_full_scale_trim_code == TRIM_NEUTRAL)
      && (o_common_mode_buffer_strength == CMB_LOW) && o_mode_quad)
    else $error("defaults wrong after reset");
endmodule // converter_config_register_bank
`default_nettype wire

// [rtl/crosspoint_decode.sv]
// decodes one core's source select code into an input pair index
// assumes the code comes straight from a register word
`timescale 1ns/10ps
`default_nettype none
module crosspoint_decode
  import conv_cfg_pkg::*;
(
  input wire logic [SRC_W-1:0] i_code,
  output logic [SEL_W-1:0] o_sel,
  output logic o_valid
);
  always_comb begin
    o_sel = '0;
    o_valid = 1'b1;
    unique case (i_code)
      SRC_PAIR_1: o_sel = 2'h0;
      SRC_PAIR_2: o_sel = 2'h1;
      SRC_PAIR_3: o_sel = 2'h2;
      SRC_PAIR_4: o_sel = 2'h3;
      // lowest bit set or not one-hot
      default: o_valid = 1'b0;
    endcase
  end
endmodule // crosspoint_decode
`default_nettype wire

// [tb/cfg_host_model.sv]
// host side of the configuration bank: completed writes and readback
// assumes callers enter its tasks just after a rising edge of i_sys_clk
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model
  import conv_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_wr_valid,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [DATA_W-1:0] o_wr_data,
  output logic [ADDR_W-1:0] o_rd_addr
);
  initial begin
    o_wr_valid = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_addr = 8'h00;
  end

  // hold keeps the strobe up for a back-to-back follow-on command
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit hold);
    o_wr_valid = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(posedge i_sys_clk);
    #1;
    if (!hold) begin
      o_wr_valid = 1'b0;
      o_wr_addr = ~a;
      o_wr_data = ~d;
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    o_rd_addr = a;
    @(posedge i_sys_clk);
    #1;
    d = i_rd_data;
  endtask
endmodule // cfg_host_model
`default_nettype wire

// [tb/converter_config_register_bank_tb_top.sv]
// self-checking bench of the converter configuration bank
// assumes the host model drives every write and readback
`timescale 1ns/10ps
`default_nettype none
module converter_config_register_bank_tb_top;
  import conv_cfg_pkg::*;
  logic i_sys_clk;
  logic i_rst;
  logic wr_valid;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic m_single, m_dual, m_quad, m_inv, tick, cur_inv, cmb_en;
  logic [3:0] branches, div_factor, src_valid;
  logic [7:0] core_chan, src_sel;
  logic [5:0] trim;
  logic [2:0] cur_code, cut;
  logic [1:0] cmb;
  logic [15:0] mode_vec, misc_vec, src_vec;
  int failures;
  int total_checks;

  assign mode_vec = {m_single, m_dual, m_quad, m_inv, branches, core_chan};
  assign misc_vec = {cur_code, cut, cur_inv, cmb, cmb_en, trim};
  assign src_vec = {4'h0, src_valid, src_sel};

  converter_config_register_bank uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_wr_valid(wr_valid),
    .i_cfg_wr_addr(wr_addr), .i_cfg_wr_data(wr_data), .i_cfg_rd_addr(rd_addr),
    .o_cfg_rd_data(rd_data), .o_mode_single(m_single), .o_mode_dual(m_dual),
    .o_mode_quad(m_quad), .o_mode_invalid(m_inv), .o_branches_per_channel(branches),
    .o_core_channel(core_chan), .o_clk_div_factor(div_factor), .o_sample_tick(tick),
    .o_core_source_sel(src_sel), .o_core_source_valid(src_valid),
    .o_full_scale_trim_code(trim), .o_core_current_code(cur_code),
    .o_core_current_cut_steps(cut), .o_core_current_invalid(cur_inv),
    .o_common_mode_buffer_strength(cmb), .o_cm_buffer_enable(cmb_en)
  );

  cfg_host_model host (
    .i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  // cycles from one tick to the next
  task automatic tick_period(output int n);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 20) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 20);
  endtask

  task automatic t_defaults();
    chk(mode_vec, {3'b001, 1'b0, 4'h2, 8'hE4});
    chk(misc_vec, {3'h0, 3'h0, 1'b0, 2'h1, 1'b1, 6'h20});
    chk(src_vec, {4'h0, 4'hF, 8'hE4});
    chk({12'h000, div_factor}, 16'h0001);
    chk({15'h0000, tick}, 16'h0001);
    rdchk(ADDR_MODE_DIV, 16'h0004);
    rdchk(ADDR_SRC_12, 16'h0402);
    rdchk(ADDR_SRC_34, 16'h1008);
    rdchk(ADDR_CURRENT, 16'h0010);
    rdchk(ADDR_FS_TRIM, 16'h0020);
    rdchk(ADDR_SOFT_RESET, 16'h0000);
  endtask

  task automatic t_modes();
    int n;
    logic [7:0] ch;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      ch = (i == 0) ? 8'h00 : (i == 1) ? 8'h50 : 8'hE4;
      w = {6'h00, 2'(i), 5'h00, 3'(1 << ((i > 2) ? 2 : i))};
      // power-down cycle after the mode change is outside this bank
      host.wr(ADDR_MODE_DIV, w, 1'b0);
      chk(mode_vec, {3'(4 >> ((i > 2) ? 2 : i)), 1'b0, 4'(8 >> ((i > 2) ? 2 : i)), ch});
      chk({12'h000, div_factor}, 16'(1 << i));
      tick_period(n);
      chk(16'(n), 16'(1 << i));
      rdchk(ADDR_MODE_DIV, w);
    end
  endtask

  task automatic t_sources();
    logic [15:0] w12, w34;
    logic [7:0] sel;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 4; k++) sel[2*k +: 2] = 2'((p + k) % 4);
      w12 = {3'h0, 5'(2 << sel[3:2]), 3'h0, 5'(2 << sel[1:0])};
      w34 = {3'h0, 5'(2 << sel[7:6]), 3'h0, 5'(2 << sel[5:4])};
      host.wr(ADDR_SRC_12, w12, 1'b1);
      host.wr(ADDR_SRC_34, w34, 1'b0);
      chk(src_vec, {4'h0, 4'hF, sel});
      rdchk(ADDR_SRC_12, w12);
      rdchk(ADDR_SRC_34, w34);
    end
    // zero bit set in the core one field gives no valid pair
    host.wr(ADDR_SRC_12, 16'h0403, 1'b0);
    chk(src_vec, {4'h0, 4'hE, sel[7:4], 2'h1, 2'h0});
  endtask

  task automatic t_analog();
    logic [15:0] w;
    for (int c = 0; c < 8; c++) begin
      if (c inside {[1:3]}) continue;
      w = {10'h000, 2'(c % 4), 1'b0, 3'(c)};
      host.wr(ADDR_CURRENT, w, 1'b1);
      host.wr(ADDR_FS_TRIM, {10'h000, 6'(c * 9)}, 1'b0);
      chk(misc_vec, {3'(c), ((c >= 4) ? 3'(8 - c) : 3'h0), 1'b0, 2'(c % 4),
                     1'(c % 4 != 0), 6'(c * 9)});
      rdchk(ADDR_CURRENT, w);
    end
  endtask

  task automatic t_soft_reset();
    // strobe held across both writes; bit zero clear, so no reset
    host.wr(ADDR_CURRENT, 16'h0030, 1'b1);
    host.wr(ADDR_SOFT_RESET, 16'h0000, 1'b0);
    repeat (3) @(posedge i_sys_clk);
    #1;
    rdchk(8'h77, 16'h0000);
    rdchk(ADDR_MODE_DIV, 16'h0304);
    rdchk(ADDR_FS_TRIM, 16'h003F);
    rdchk(ADDR_CURRENT, 16'h0030);
    host.wr(ADDR_SOFT_RESET, 16'h0001, 1'b0);
    t_defaults();
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    total_checks = 0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    t_defaults();
    t_modes();
    t_sources();
    t_analog();
    t_soft_reset();
    wrap_up();
  end
endmodule // converter_config_register_bank_tb_top
`default_nettype wire
